// ---- acfd_top.sv ----
// Amplifier control word: serial load, holding register, decoded switch outputs.
// Assumes serial pins synchronous to mclk_i; host bus is a plain strobe port.
//
// What this block does
// - Compensation code 0..3 selects its own level and any code with top bit set the fifth.
// - The compensation field sits in control word bits 5 to 3.
// - Routing select and polarity invert sit in control word bits 8 to 6.
// - Routing 00b with polarity 0 connects the inputs normally.
// - Routing 00b with polarity 1 swaps the two inputs.
// - Routing 01b with polarity 0 ties both amplifier inputs to the positive pin.
// - Routing 01b with polarity 1 ties both amplifier inputs to the negative pin.
// - Routing 10b or 11b divides one pin by fifty and ties the spare input to the rail.
// - Divided modes give overall gains 0.2 to 20, negated when polarity is set.
// - Bit 9 set requests shutdown, clear means active.
// - Sixteen serial bits shift in and reach the holding register only on select rising.
// - Gain code in bits 2 to 0 selects 10x to 1000x, or external resistors for 111b.
`include "acfd_regs.svh"

module acfd_top
    import acfd_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic sclk_i,
    input wire logic sdata_i,
    input wire logic select_n_i,
    output logic sdata_o,
    input wire logic [1:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    output acfd_route_s route_o,
    output acfd_misc_s misc_o,
    output logic power_down_request_o
);

    // ----------------------------------------
    // Serial pin edges
    // ----------------------------------------
    logic sclk_q;
    logic sel_n_q;
    logic [15:0] shift_q;
    logic [15:0] shift_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic full_q;
    logic full_d;
    logic [15:0] hold_q;
    logic [15:0] hold_d;
    logic load_seen_q;
    logic [15:0] rdata_d;
    acfd_state_e state_q;
    acfd_state_e state_d;
    acfd_route_s route_c;
    acfd_misc_s misc_c;

    wire logic sclk_rise = sclk_i & ~sclk_q;
    wire logic sel_fall = ~select_n_i & sel_n_q;
    wire logic sel_rise = select_n_i & ~sel_n_q;
    wire logic framing = ~select_n_i & (state_q != ACFD_IDLE);

    // ----------------------------------------
    // Serial frame state
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ACFD_IDLE: begin
                if (sel_fall) begin
                    state_d = ACFD_SHIFT;
                end
            end
            ACFD_SHIFT: begin
                if (sel_rise) begin
                    state_d = ACFD_IDLE;
                end else if (sclk_rise && cnt_q == `ACFD_CNT_LAST) begin
                    state_d = ACFD_DONE;
                end
            end
            ACFD_DONE: begin
                if (sel_rise) begin
                    state_d = ACFD_IDLE;
                end
            end
            default: state_d = ACFD_IDLE;
        endcase
    end

    // Shift keeps running past sixteen so daisy chains pass data on
    assign shift_d = (framing && sclk_rise) ? {shift_q[14:0], sdata_i} : shift_q;
    assign cnt_d = sel_fall ? `ACFD_CNT_RST :
                   (framing && sclk_rise) ? 4'(cnt_q + 4'h1) : cnt_q;
    assign full_d = sel_fall ? 1'b0 : (full_q | (state_q == ACFD_DONE));

    // ----------------------------------------
    // Holding register
    // ----------------------------------------
    // Serial load needs all sixteen bits; a bus write loads directly
    wire logic ser_load = sel_rise & (state_q == ACFD_DONE);
    wire logic bus_load = wr_i & (addr_i == `ACFD_ADDR_WORD);
    assign hold_d = ser_load ? shift_q : (bus_load ? wdata_i : hold_q);

    // ----------------------------------------
    // Register read port
    // ----------------------------------------
    wire logic [15:0] stat_word = {9'h000, full_q, load_seen_q, cnt_q, ~select_n_i};
    wire logic [15:0] swch_word = {6'h00, route_c};
    wire logic [15:0] gain_word = {misc_c.div_gain_negative, 6'h00,
                                   misc_c.gain_user, misc_c.div_gain_tenths};
    always_comb begin
        rdata_d = 16'h0000;
        if (rd_i) begin
            unique case (addr_i)
                `ACFD_ADDR_WORD: rdata_d = hold_q;
                `ACFD_ADDR_STAT: rdata_d = stat_word;
                `ACFD_ADDR_SWCH: rdata_d = swch_word;
                `ACFD_ADDR_GAIN: rdata_d = gain_word;
            endcase
        end
    end

    // ----------------------------------------
    // Decoder
    // ----------------------------------------
    acfd_decode acfd_decode_inst (
        .word_i(hold_q),
        .route_o(route_c),
        .misc_o(misc_c)
    );

    // ----------------------------------------
    // Flip-flops
    // ----------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_q <= 1'b1;
            sel_n_q <= 1'b1;
            state_q <= ACFD_IDLE;
            shift_q <= `ACFD_WORD_RST;
            cnt_q <= `ACFD_CNT_RST;
            full_q <= 1'b0;
            hold_q <= `ACFD_WORD_RST;
            load_seen_q <= 1'b0;
        end else begin
            sclk_q <= sclk_i;
            sel_n_q <= select_n_i;
            state_q <= state_d;
            shift_q <= shift_d;
            cnt_q <= cnt_d;
            full_q <= full_d;
            hold_q <= hold_d;
            load_seen_q <= load_seen_q | ser_load | bus_load;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 16'h0000;
            sdata_o <= 1'b0;
            route_o <= '0;
            misc_o <= '0;
            power_down_request_o <= 1'b0;
        end else begin
            rdata_o <= rdata_d;
            sdata_o <= shift_q[15];
            route_o <= route_c;
            misc_o <= misc_c;
            power_down_request_o <= misc_c.power_down;
        end
    end

endmodule

// ---- acfd_regs.svh ----
// Constants for the amplifier control word decoder.
// Assumes inclusion by bare name from the package and design files.
`ifndef ACFD_REGS_SVH
`define ACFD_REGS_SVH

`define ACFD_WORD_W 16
`define ACFD_WORD_RST 16'h0000
`define ACFD_GAIN_LSB 0
`define ACFD_GAIN_MSB 2
`define ACFD_COMP_LSB 3
`define ACFD_COMP_MSB 5
`define ACFD_ROUTE_LSB 6
`define ACFD_ROUTE_MSB 7
`define ACFD_INV_BIT 8
`define ACFD_PD_BIT 9
`define ACFD_FILT_BIT 10
`define ACFD_CNT_LAST 4'hf
`define ACFD_CNT_RST 4'h0
`define ACFD_ADDR_W 2
`define ACFD_ADDR_WORD 2'h0
`define ACFD_ADDR_STAT 2'h1
`define ACFD_ADDR_SWCH 2'h2
`define ACFD_ADDR_GAIN 2'h3
`define ACFD_ROUTE_NORM 2'h0
`define ACFD_ROUTE_SHORT 2'h1
`define ACFD_ROUTE_DIVP 2'h2
`define ACFD_ROUTE_DIVN 2'h3
`define ACFD_GAIN_USER 3'h7
// Overall gain in tenths for divided routes, codes 0..6
`define ACFD_DG0 8'h02
`define ACFD_DG1 8'h04
`define ACFD_DG2 8'h0a
`define ACFD_DG3 8'h14
`define ACFD_DG4 8'h28
`define ACFD_DG5 8'h64
`define ACFD_DG6 8'hc8

`endif

// ---- acfd_pkg.sv ----
// Types for the amplifier control word decoder.
// Assumes acfd_regs.svh is on the include path.
`include "acfd_regs.svh"

package acfd_pkg;

    typedef enum logic [4:0] {
        ACFD_COMP_L0 = 5'b00001,
        ACFD_COMP_L1 = 5'b00010,
        ACFD_COMP_L2 = 5'b00100,
        ACFD_COMP_L3 = 5'b01000,
        ACFD_COMP_L4 = 5'b10000
    } acfd_comp_e;

    typedef enum logic [2:0] {
        ACFD_IDLE = 3'b001,
        ACFD_SHIFT = 3'b010,
        ACFD_DONE = 3'b100
    } acfd_state_e;

    // Analog switch controls
    typedef struct packed {
        logic amp_p_from_pin_p;
        logic amp_p_from_pin_n;
        logic amp_p_from_div;
        logic amp_n_from_pin_p;
        logic amp_n_from_pin_n;
        logic amp_n_from_div;
        logic amp_n_to_rail;
        logic amp_p_to_rail;
        logic div_from_pin_p;
        logic div_from_pin_n;
    } acfd_route_s;

    typedef struct packed {
        logic [4:0] comp_level;
        logic [6:0] gain_onehot;
        logic gain_user;
        logic fb_switch_closed;
        logic power_down;
        logic [7:0] div_gain_tenths;
        logic div_gain_negative;
    } acfd_misc_s;

endpackage

// ---- acfd_decode.sv ----
// Combinational field decoder for the amplifier control word.
// Assumes its input is the holding register, stable between loads.
`include "acfd_regs.svh"

module acfd_decode
    import acfd_pkg::*;
(
    input wire logic [15:0] word_i,
    output acfd_route_s route_o,
    output acfd_misc_s misc_o
);

    // ----------------------------------------
    // Field extraction
    // ----------------------------------------
    wire logic [2:0] gain_code = word_i[`ACFD_GAIN_MSB:`ACFD_GAIN_LSB];
    wire logic [2:0] comp_code = word_i[`ACFD_COMP_MSB:`ACFD_COMP_LSB];
    wire logic [1:0] route_code = word_i[`ACFD_ROUTE_MSB:`ACFD_ROUTE_LSB];
    wire logic inv = word_i[`ACFD_INV_BIT];
    wire logic user_gain = (gain_code == `ACFD_GAIN_USER);
    wire logic is_norm = (route_code == `ACFD_ROUTE_NORM);
    wire logic is_short = (route_code == `ACFD_ROUTE_SHORT);
    wire logic is_divp = (route_code == `ACFD_ROUTE_DIVP);
    wire logic is_divn = (route_code == `ACFD_ROUTE_DIVN);
    wire logic is_div = is_divp | is_divn;

    function automatic logic [4:0] comp_dec(input logic [2:0] c);
        if (c[2]) begin
            return ACFD_COMP_L4;
        end
        unique case (c[1:0])
            2'h0: return ACFD_COMP_L0;
            2'h1: return ACFD_COMP_L1;
            2'h2: return ACFD_COMP_L2;
            2'h3: return ACFD_COMP_L3;
        endcase
    endfunction

    function automatic logic [7:0] div_gain(input logic [2:0] g);
        unique case (g)
            3'h0: return `ACFD_DG0;
            3'h1: return `ACFD_DG1;
            3'h2: return `ACFD_DG2;
            3'h3: return `ACFD_DG3;
            3'h4: return `ACFD_DG4;
            3'h5: return `ACFD_DG5;
            3'h6: return `ACFD_DG6;
            3'h7: return 8'h00;
        endcase
    endfunction

    // ----------------------------------------
    // Input routing switches
    // ----------------------------------------
    assign route_o.amp_p_from_pin_p = (is_norm | is_short) & ~inv;
    assign route_o.amp_n_from_pin_n = (is_norm & ~inv) | (is_short & inv);
    assign route_o.amp_p_from_pin_n = (is_norm | is_short) & inv;
    assign route_o.amp_n_from_pin_p = (is_norm & inv) | (is_short & ~inv);
    // Divided pin feeds the input chosen by polarity; the other goes to the rail
    assign route_o.amp_p_from_div = is_div & ~inv;
    assign route_o.amp_n_from_div = is_div & inv;
    assign route_o.amp_n_to_rail = is_div & ~inv;
    assign route_o.amp_p_to_rail = is_div & inv;
    assign route_o.div_from_pin_p = is_divp;
    assign route_o.div_from_pin_n = is_divn;

    // ----------------------------------------
    // Compensation, gain, power
    // ----------------------------------------
    assign misc_o.comp_level = comp_dec(comp_code);
    assign misc_o.gain_onehot = user_gain ? 7'h00 : 7'(8'h01 << gain_code);
    assign misc_o.gain_user = user_gain;
    assign misc_o.fb_switch_closed = user_gain | word_i[`ACFD_FILT_BIT];
    assign misc_o.power_down = word_i[`ACFD_PD_BIT];
    assign misc_o.div_gain_tenths = is_div ? div_gain(gain_code) : 8'h00;
    assign misc_o.div_gain_negative = is_div & inv;

endmodule

// ---- acfd_checker.sv ----
// Concurrent checks on the decoder's registered outputs.
// Assumes binding onto acfd_top, one clock domain.
module acfd_checker
    import acfd_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic select_n_i,
    input wire logic wr_i,
    input wire acfd_route_s route_o,
    input wire acfd_misc_s misc_o,
    input wire logic power_down_request_o
);
    // ----------------------------------------
    // Output relations
    // ----------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    // Frame in progress, no bus write: nothing can load
    sequence quiet_s;
        (!select_n_i && !wr_i) [*5];
    endsequence

    chk_reset_zero: assert property (disable iff (1'b0) !rst_n_i |->
        route_o == '0 && misc_o == '0 && !power_down_request_o)
        else $error("outputs not cleared in reset");
    chk_comp_onehot: assert property ($past(rst_n_i) |-> $onehot(misc_o.comp_level))
        else $error("compensation level not one-hot");
    chk_gain_onehot: assert property ($past(rst_n_i) |->
        $onehot({misc_o.gain_onehot, misc_o.gain_user}))
        else $error("gain select not one-hot");
    chk_pos_source: assert property ($past(rst_n_i) |-> $onehot({route_o.amp_p_from_pin_p,
        route_o.amp_p_from_pin_n, route_o.amp_p_from_div, route_o.amp_p_to_rail}))
        else $error("positive amplifier input has no single source");
    chk_neg_source: assert property ($past(rst_n_i) |-> $onehot({route_o.amp_n_from_pin_p,
        route_o.amp_n_from_pin_n, route_o.amp_n_from_div, route_o.amp_n_to_rail}))
        else $error("negative amplifier input has no single source");
    chk_div_rail: assert property (route_o.amp_p_from_div |->
        route_o.amp_n_to_rail && !misc_o.div_gain_negative)
        else $error("divided route spare input not on rail");
    chk_div_negate: assert property (misc_o.div_gain_negative |->
        route_o.amp_n_from_div && route_o.amp_p_to_rail)
        else $error("negated divided gain without swapped route");
    chk_pd_copy: assert property (power_down_request_o == misc_o.power_down)
        else $error("shutdown outputs disagree");
    chk_hold_steady: assert property (quiet_s |-> $stable(route_o) && $stable(misc_o))
        else $error("outputs moved while shifting");
endmodule

bind acfd_top acfd_checker acfd_checker_inst (.mclk_i, .rst_n_i, .select_n_i, .wr_i,
    .route_o, .misc_o, .power_down_request_o);

// ---- acfd_host.sv ----
// Serial host model that loads control words, MSB first.
// Assumes a 100 MHz mclk; the serial clock idles high between frames.
module acfd_host
(
    input wire logic mclk_i,
    output logic sclk_o,
    output logic sdata_o,
    output logic select_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Frame generation
    // ----------------------------------------
    initial begin
        sclk_o = 1'b1;
        sdata_o = 1'b0;
        select_n_o = 1'b1;
    end

    // Clock high at both select edges, data set while clock low
    task automatic send(input logic [15:0] w, input int n);
        @(posedge mclk_i);
        select_n_o <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge mclk_i);
            sclk_o <= 1'b0;
            sdata_o <= w[i];
            repeat (2) @(posedge mclk_i);
            sclk_o <= 1'b1;
            @(posedge mclk_i);
        end
        @(posedge mclk_i);
        select_n_o <= 1'b1;
        sdata_o <= ~sdata_o;
    endtask
endmodule

// ---- tb_top.sv ----
// Self-checking bench: serial loads and bus accesses with expected outputs.
// Assumes acfd_host as the serial host and the checker bound onto acfd_top.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import acfd_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b1;
    logic sdata_out;
    // Compensation per gain code, kept within the host's stability limits
    logic [2:0] comp_tab [8] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h2, 3'h3, 3'h4, 3'h7};
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [1:0] addr_i = 2'h0;
    logic [15:0] wdata_i = 16'h0000;
    logic sclk;
    logic sdata;
    logic select_n;
    logic [15:0] rdata_o;
    acfd_route_s route_o;
    acfd_misc_s misc_o;
    logic power_down_request_o;
    int error_cnt = 0;
    int n_tests = 0;
    logic [7:0] tenths [7] = '{8'h02, 8'h04, 8'h0a, 8'h14, 8'h28, 8'h64, 8'hc8};

    always #5 mclk_i = ~mclk_i;

    acfd_host acfd_host_inst (.mclk_i, .sclk_o(sclk), .sdata_o(sdata), .select_n_o(select_n));
    acfd_top acfd_top_inst (.mclk_i, .rst_n_i, .sclk_i(sclk), .sdata_i(sdata),
        .select_n_i(select_n), .sdata_o(sdata_out), .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .route_o, .misc_o, .power_down_request_o);

    // ----------------------------------------
    // Access and compare tasks
    // ----------------------------------------
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge mclk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, input logic [15:0] e, input string nm);
        @(posedge mclk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        chk(nm, e, rdata_o);
    endtask

    task automatic load(input logic [15:0] w, input int n);
        acfd_host_inst.send(w, n);
        repeat (4) @(posedge mclk_i);
        #1;
    endtask

    function automatic acfd_route_s exp_route(input logic [1:0] r, input logic p);
        if (r == 2'h0) return acfd_route_s'({!p, p, 1'b0, p, !p, 5'h00});
        if (r == 2'h1) return acfd_route_s'({!p, p, 1'b0, !p, p, 5'h00});
        return acfd_route_s'({2'b00, !p, 2'b00, p, !p, p, !r[0], r[0]});
    endfunction

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        logic [15:0] w;
        logic [2:0] c;
        acfd_route_s er;
        #1;
        rst_n_i = 1'b0;
        repeat (6) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        #1;
        chk("reset route", {6'h00, exp_route(2'h0, 1'b0)}, {6'h00, route_o});
        chk("reset comp", 16'h0001, {11'h000, misc_o.comp_level});
        rd(2'h0, 16'h0000, "reset word");
        for (int i = 0; i < 8; i++) begin
            c = comp_tab[i];
            w = {6'h00, i[0], i[2], i[1:0], c, i[2:0]};
            er = exp_route(i[1:0], i[2]);
            load(w, 16);
            chk("route", {6'h00, er}, {6'h00, route_o});
            chk("comp", c[2] ? 16'h0010 : 16'h0001 << c[1:0],
                {11'h000, misc_o.comp_level});
            chk("feedback switch", {15'h0000, i == 7},
                {15'h0000, misc_o.fb_switch_closed});
            chk("power down", {15'h0000, i[0]}, {15'h0000, power_down_request_o});
            chk("gain", (i < 7) ? 16'h0002 << i : 16'h0001,
                {8'h00, misc_o.gain_onehot, misc_o.gain_user});
            rd(2'h0, w, "word");
            rd(2'h2, {6'h00, er}, "route reg");
        end
        for (int i = 0; i < 7; i++) begin
            load({7'h00, i[0], 2'h3, 3'h0, i[2:0]}, 16);
            chk("divided gain out", {i[0], 7'h00, tenths[i]},
                {misc_o.div_gain_negative, 7'h00, misc_o.div_gain_tenths});
            rd(2'h3, {i[0], 7'h00, tenths[i]}, "divided gain");
        end
        er = route_o;
        load(16'h0240, 15);
        chk("short frame", {6'h00, er}, {6'h00, route_o});
        rd(2'h1, 16'h003e, "status short frame");
        wr(2'h2, 16'hffff);
        rd(2'h2, {6'h00, er}, "refused write");
        load(16'h8000, 16);
        chk("serial out", 16'h0001, {15'h0000, sdata_out});
        rd(2'h1, 16'h0060, "status full frame");
        rd(2'h0, 16'h8000, "word top bit");
        wr(2'h0, 16'h0600);
        repeat (3) @(posedge mclk_i);
        #1;
        chk("bus power down", 16'h0001, {15'h0000, power_down_request_o});
        chk("bus feedback switch", 16'h0001, {15'h0000, misc_o.fb_switch_closed});
        results();
    end

    initial begin
        #100000;
        error_cnt++;
        results();
    end
endmodule
